//--- src/tmiw_defines.vh
// Constants for the timer match interrupt and wake-up block
`ifndef TMIW_DEFINES_VH
`define TMIW_DEFINES_VH
// ============================================================
// Widths and defaults
`define TMIW_NUM_TIMERS 3
`define TMIW_NUM_GROUPS 3
`define TMIW_PC_W 11
`define TMIW_VEC_W 11
`define TMIW_GEI_RST 1'b0
`define TMIW_FLAG_RST 1'b0
// ============================================================
// Entry sequencer states
`define TMIW_ST_RUN 2'h0
`define TMIW_ST_ENTRY 2'h1
`define TMIW_ST_VECTOR 2'h2
`endif

//--- src/tmiw_flag.v
// One sticky request flag with set-over-clear priority
`timescale 1ns/10ps
module tmiw_flag (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire set_i,
  input wire clr_i,
  input wire wr_i,
  input wire wr_val_i,
  output reg flag_o
);
`include "tmiw_defines.vh"
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_o <= `TMIW_FLAG_RST;
    end else if (ce_i) begin
      // A set in the same cycle as a clear is not lost
      if (set_i) begin
        flag_o <= 1'b1;
      end else if (wr_i) begin
        flag_o <= wr_val_i;
      end else if (clr_i) begin
        flag_o <= 1'b0;
      end
    end
  end
endmodule

//--- src/tmiw_rise.v
// Rising-edge detector for a wake-up source
`timescale 1ns/10ps
module tmiw_rise #(
  parameter W = 1
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  output wire rise_o
);
  reg [W-1:0] prev_r;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_r <= {W{1'b0}};
    end else if (ce_i) begin
      prev_r <= d_i;
    end
  end
  // Enables are not looked at here on purpose
  assign rise_o = |(d_i & ~prev_r);
endmodule

//--- src/tmiw_top.v
// Timer match interrupt controller with wake-up and entry/return sequencing
`timescale 1ns/10ps
`include "tmiw_defines.vh"
module tmiw_top #(
  parameter NT = `TMIW_NUM_TIMERS,
  parameter NG = `TMIW_NUM_GROUPS,
  parameter PCW = `TMIW_PC_W
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  // Timer comparator events, one-cycle pulses
  input wire [NT-1:0] period_match_i,
  input wire [NT-1:0] compare_match_i,
  // Group membership of each timer, one-hot per timer, flattened
  input wire [NT*NG-1:0] timer_group_map_i,
  // Software access to flags: write strobe with value
  input wire [NT-1:0] period_flag_wr_i,
  input wire [NT-1:0] period_flag_wr_val_i,
  input wire [NT-1:0] compare_flag_wr_i,
  input wire [NT-1:0] compare_flag_wr_val_i,
  input wire [NG-1:0] group_flag_wr_i,
  input wire [NG-1:0] group_flag_wr_val_i,
  input wire gie_wr_i,
  input wire gie_wr_val_i,
  // Enables
  input wire [NT-1:0] timer_period_match_enable_i,
  input wire [NT-1:0] timer_compare_match_enable_i,
  input wire [NG-1:0] multifunction_group_enable_i,
  // Core side
  input wire instr_boundary_i,
  input wire stack_full_i,
  input wire [PCW-1:0] pc_i,
  input wire [NG*PCW-1:0] group_vector_i,
  input wire ret_i,
  input wire return_and_reenable_i,
  input wire sleeping_i,
  // Outputs
  output wire [NT-1:0] timer_period_match_flag_o,
  output wire [NT-1:0] timer_compare_match_flag_o,
  output wire [NG-1:0] multifunction_group_flag_o,
  output reg global_interrupt_enable_o,
  output reg push_o,
  output reg [PCW-1:0] push_pc_o,
  output reg pop_o,
  output reg vector_load_o,
  output reg [PCW-1:0] vector_addr_o,
  output wire wake_o
);
  // ============================================================
  // Timer request flags
  wire [NG-1:0] group_take;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [NG-1:0] sel_r;
  genvar t;
  genvar g;
  generate
    for (t = 0; t < NT; t = t + 1) begin : g_tmr
      // Servicing leaves these set; only software clears them
      tmiw_flag u_pf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .set_i(period_match_i[t]),
        .clr_i(1'b0),
        .wr_i(period_flag_wr_i[t]),
        .wr_val_i(period_flag_wr_val_i[t]),
        .flag_o(timer_period_match_flag_o[t])
      );
      tmiw_flag u_af (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .set_i(compare_match_i[t]),
        .clr_i(1'b0),
        .wr_i(compare_flag_wr_i[t]),
        .wr_val_i(compare_flag_wr_val_i[t]),
        .flag_o(timer_compare_match_flag_o[t])
      );
    end
  endgenerate
  // ============================================================
  // Group flags: set on a new enabled timer request
  wire [NT-1:0] src_req = (timer_period_match_flag_o & timer_period_match_enable_i) |
                          (timer_compare_match_flag_o & timer_compare_match_enable_i);
  reg [NT-1:0] src_req_d_r;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_req_d_r <= {NT{1'b0}};
    end else if (ce_i) begin
      src_req_d_r <= src_req;
    end
  end
  wire [NT-1:0] src_new = src_req & ~src_req_d_r;
  generate
    for (g = 0; g < NG; g = g + 1) begin : g_grp
      wire [NT-1:0] members;
      for (t = 0; t < NT; t = t + 1) begin : g_m
        assign members[t] = timer_group_map_i[t*NG+g];
      end
      tmiw_flag u_mf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .set_i(|(src_new & members)),
        .clr_i(group_take[g]),
        .wr_i(group_flag_wr_i[g]),
        .wr_val_i(group_flag_wr_val_i[g]),
        .flag_o(multifunction_group_flag_o[g])
      );
    end
  endgenerate
  // ============================================================
  // Wake-up on any flag rising, enables ignored
  wire rise_any;
  tmiw_rise #(
    .W(2*NT+NG)
  ) u_wake (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .d_i({multifunction_group_flag_o, timer_compare_match_flag_o, timer_period_match_flag_o}),
    .rise_o(rise_any)
  );
  // Qualified by the sleep state so a running core sees no spurious wake
  assign wake_o = rise_any & sleeping_i;
  // ============================================================
  // Priority select of the lowest pending enabled group
  wire [NG-1:0] gated = multifunction_group_flag_o & multifunction_group_enable_i;
  wire [NG-1:0] pick = gated & ~(gated - {{(NG-1){1'b0}}, 1'b1});
  wire take = global_interrupt_enable_o & (|gated) & ~stack_full_i &
              instr_boundary_i & (state_r == `TMIW_ST_RUN);
  assign group_take = take ? pick : {NG{1'b0}};
  reg [PCW-1:0] vec_sel;
  integer k;
  always @* begin
    vec_sel = {PCW{1'b0}};
    for (k = 0; k < NG; k = k + 1) begin
      if (sel_r[k]) begin
        vec_sel = group_vector_i[k*PCW +: PCW];
      end
    end
  end
  // ============================================================
  // Entry sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `TMIW_ST_RUN: begin
        if (take) begin
          state_nxt = `TMIW_ST_ENTRY;
        end
      end
      `TMIW_ST_ENTRY: begin
        state_nxt = `TMIW_ST_VECTOR;
      end
      `TMIW_ST_VECTOR: begin
        state_nxt = `TMIW_ST_RUN;
      end
      default: begin
        state_nxt = `TMIW_ST_RUN;
      end
    endcase
  end
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= `TMIW_ST_RUN;
      sel_r <= {NG{1'b0}};
      global_interrupt_enable_o <= `TMIW_GEI_RST;
      push_o <= 1'b0;
      push_pc_o <= {PCW{1'b0}};
      pop_o <= 1'b0;
      vector_load_o <= 1'b0;
      vector_addr_o <= {PCW{1'b0}};
    end else if (ce_i) begin
      state_r <= state_nxt;
      push_o <= 1'b0;
      pop_o <= 1'b0;
      vector_load_o <= 1'b0;
      if (take) begin
        sel_r <= pick;
        global_interrupt_enable_o <= 1'b0;
      end else if (return_and_reenable_i) begin
        pop_o <= 1'b1;
        global_interrupt_enable_o <= 1'b1;
      end else if (ret_i) begin
        pop_o <= 1'b1;
      end else if (gie_wr_i) begin
        global_interrupt_enable_o <= gie_wr_val_i;
      end
      if (state_r == `TMIW_ST_ENTRY) begin
        push_o <= 1'b1;
        push_pc_o <= pc_i;
      end
      if (state_r == `TMIW_ST_VECTOR) begin
        vector_load_o <= 1'b1;
        vector_addr_o <= vec_sel;
      end
    end
  end
endmodule

//--- tb/tb_top.sv
// Self-checking testbench for the timer match interrupt block
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 0, reset_n_i = 0, sleeping_i = 0, gie_wr_i = 0, gie_wr_val_i = 0, stack_full_i = 0, clk_en = 1;
  logic ret_i = 0, rer_i = 0, bnd, gie, push, pop, vl, wake;
  logic [2:0] pm = 0, cm = 0, pwr = 0, pval = 0, cwr = 0, cval = 0, gwr = 0, pe = 0, ce_en = 0, ge = 0;
  logic [2:0] pf, cf, gf, gval = 0;
  logic [10:0] pc, ppc, va;
  integer error_cnt = 0, n_tests = 0;
  wire [3:0] ev = {wake, vl, pop, push};
  always #20 clk_i = ~clk_i;
  tmiw_top #(.NT(3), .NG(3), .PCW(11)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(clk_en),
    .period_match_i(pm), .compare_match_i(cm), .timer_group_map_i(9'h111), .period_flag_wr_i(pwr),
    .period_flag_wr_val_i(pval), .compare_flag_wr_i(cwr), .compare_flag_wr_val_i(cval), .group_flag_wr_i(gwr),
    .group_flag_wr_val_i(gval), .gie_wr_i(gie_wr_i), .gie_wr_val_i(gie_wr_val_i),
    .timer_period_match_enable_i(pe), .timer_compare_match_enable_i(ce_en), .multifunction_group_enable_i(ge),
    .instr_boundary_i(bnd), .stack_full_i(stack_full_i), .pc_i(pc), .group_vector_i({11'h00c, 11'h008, 11'h004}),
    .ret_i(ret_i), .return_and_reenable_i(rer_i), .sleeping_i(sleeping_i), .timer_period_match_flag_o(pf),
    .timer_compare_match_flag_o(cf), .multifunction_group_flag_o(gf), .global_interrupt_enable_o(gie),
    .push_o(push), .push_pc_o(ppc), .pop_o(pop), .vector_load_o(vl), .vector_addr_o(va), .wake_o(wake));
  tmiw_core_model i_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .push_i(push), .push_pc_i(ppc), .pop_i(pop),
    .load_i(vl), .addr_i(va), .boundary_o(bnd), .pc_o(pc));
  // ====
  // Helpers
  task results;
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Waits on one event bit; a hang ends the run
  task wt(input int b);
    int i;
    for (i = 0; i < 30; i++) begin
      @(negedge clk_i);
      if (ev[b] === 1'b1) break;
    end
    if (i == 30) begin
      chk(0, 1);
      results;
    end
  endtask
  task ret_pulse(input bit re);
    @(posedge clk_i);
    if (re) rer_i <= 1; else ret_i <= 1;
    @(posedge clk_i);
    rer_i <= 0;
    ret_i <= 0;
    wt(1);
  endtask
  // ====
  // Scenarios
  task t_take;
    @(posedge clk_i);
    {pe, ge, gie_wr_i, gie_wr_val_i} <= 8'h27;
    @(posedge clk_i);
    {gie_wr_i, pm} <= 4'h1;
    @(posedge clk_i);
    pm <= 0;
    wt(0);
    chk(ppc, 11'h123);
    chk(gie, 0);
    chk(gf, 0);
    chk(pf, 1);
    @(negedge clk_i) chk({vl, va}, 12'h804);
    ret_pulse(0);
    @(negedge clk_i) chk(gie, 0);
    ret_pulse(1);
    @(negedge clk_i) chk({gie, pf, gf}, 7'h48);
  endtask
  task t_stall;
    @(posedge clk_i);
    {pe, stack_full_i} <= 4'h1;
    @(posedge clk_i);
    pe <= 1;
    repeat (6) @(negedge clk_i);
    chk({gie, gf}, 4'h9);
    @(posedge clk_i) stack_full_i <= 0;
    wt(0);
    ret_pulse(1);
    @(posedge clk_i) {pwr, pval, pe} <= 9'h040;
    @(posedge clk_i) pwr <= 0;
    @(negedge clk_i) chk({pf, gie}, 4'h1);
  endtask
  task t_wake;
    @(posedge clk_i) {sleeping_i, gie_wr_i, gie_wr_val_i, cm} <= 6'h22;
    @(posedge clk_i) {gie_wr_i, cm} <= 4'h0;
    wt(3);
    chk(cf, 3'h2);
    @(posedge clk_i) cm <= 3'h2;
    @(posedge clk_i) cm <= 0;
    repeat (4) @(negedge clk_i) chk(wake, 0);
    // Writes while the clock enable is low must be ignored
    @(posedge clk_i) {clk_en, cwr, cval, gwr, gval} <= 13'h0249;
    @(posedge clk_i) {clk_en, cwr, cval, gwr, gval} <= 13'h1000;
    @(negedge clk_i) chk({cf, gf}, 6'h10);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1;
    @(negedge clk_i) chk({pf, cf, gf, gie, push, pop, vl, wake}, 0);
    t_take;
    stack_full_i <= 1;
    t_stall;
    t_wake;
    results;
  end
endmodule

//--- tb/tmiw_core_model.sv
// Core model: program counter, one-deep return stack, instruction boundaries
`timescale 1ns/10ps
module tmiw_core_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic push_i,
  input wire logic [10:0] push_pc_i,
  input wire logic pop_i,
  input wire logic load_i,
  input wire logic [10:0] addr_i,
  output logic boundary_o,
  output logic [10:0] pc_o
);
  logic [1:0] cnt_r;
  logic [10:0] ret_r;
  // Boundary every third cycle so takes really have to wait for one
  assign boundary_o = (cnt_r == 2'h2);
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 2'h0;
      pc_o <= 11'h123;
      ret_r <= 11'h000;
    end else begin
      cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
      if (push_i)
        ret_r <= push_pc_i;
      if (load_i)
        pc_o <= addr_i;
      else if (pop_i)
        pc_o <= ret_r;
    end
  end
endmodule

//--- tb/tmiw_top_sva.sv
// Assertions on the ports of the interrupt block
`timescale 1ns/10ps
module tmiw_chk #(parameter NT = 3, parameter NG = 3, parameter PCW = 11) (
  input wire clk_i,
  input wire reset_n_i,
  input wire [NT-1:0] period_match_i,
  input wire [NT-1:0] period_flag_wr_i,
  input wire gie_wr_i,
  input wire instr_boundary_i,
  input wire ret_i,
  input wire return_and_reenable_i,
  input wire sleeping_i,
  input wire [NT-1:0] timer_period_match_flag_o,
  input wire global_interrupt_enable_o,
  input wire push_o,
  input wire pop_o,
  input wire vector_load_o,
  input wire wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ====
  // Entry, return and flags
  property p_vec; push_o |=> vector_load_o; endproperty
  a_vec: assert property (p_vec) else $error("vector load missing after push");
  property p_gie; push_o |-> !global_interrupt_enable_o; endproperty
  a_gie: assert property (p_gie) else $error("global enable not cleared on entry");
  property p_gate; !$past(global_interrupt_enable_o) && !$past(global_interrupt_enable_o, 2) |-> !push_o; endproperty
  a_gate: assert property (p_gate) else $error("entry with global enable low");
  property p_bnd; !$past(instr_boundary_i) && !$past(instr_boundary_i, 2) |-> !push_o; endproperty
  a_bnd: assert property (p_bnd) else $error("entry off a boundary");
  property p_set; |period_match_i |=> (timer_period_match_flag_o & $past(period_match_i)) == $past(period_match_i);
  endproperty
  a_set: assert property (p_set) else $error("match did not set flag");
  property p_hold; (~timer_period_match_flag_o & $past(timer_period_match_flag_o) & ~$past(period_flag_wr_i)) == 0;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without write");
  property p_rer; return_and_reenable_i |=> pop_o && global_interrupt_enable_o; endproperty
  a_rer: assert property (p_rer) else $error("reenabling return wrong");
  property p_ret; ret_i && !return_and_reenable_i && !global_interrupt_enable_o && !gie_wr_i
    |=> pop_o && !global_interrupt_enable_o; endproperty
  a_ret: assert property (p_ret) else $error("plain return wrong");
  property p_wake; sleeping_i && (timer_period_match_flag_o & ~$past(timer_period_match_flag_o)) != 0 |-> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("rising flag gave no wake");
  property p_wsl; wake_o |-> sleeping_i; endproperty
  a_wsl: assert property (p_wsl) else $error("wake while running");
  c_push: cover property (push_o);
  c_pop: cover property (pop_o);
  c_wake: cover property (wake_o);
endmodule
bind tmiw_top tmiw_chk #(.NT(NT), .NG(NG), .PCW(PCW)) i_chk (.*);
